// >>> rtl/pwt_divider.v
// programmable divider producing a one-cycle tick enable
// assumes a single clock; ratio is held stable while counting
module pwt_divider #(
  parameter W = 9
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire enable,
  input wire [W-1:0] ratio,
  // tick out
  output reg tick
);

  reg [W-1:0] cnt_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end
    else if (enable)
    begin
      if (cnt_q >= ratio - {{(W-1){1'b0}}, 1'b1})
      begin
        cnt_q <= {W{1'b0}};
        tick <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        tick <= 1'b0;
      end
    end
    else
    begin
      tick <= 1'b0;
    end
  end

endmodule

// >>> rtl/pwt_regs.vh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with one aligned word per register
`ifndef PWT_REGS_VH
`define PWT_REGS_VH

// apb byte offsets
`define PWT_REFRESH_OFF 8'h00
`define PWT_START_OFF 8'h04
`define PWT_CONTROL_OFF 8'h08
`define PWT_PROTECT_OFF 8'h0C
`define PWT_PMODE_OFF 8'h10
`define PWT_COUNT_OFF 8'h14

// refresh sequence values
`define PWT_REFRESH_FIRST 8'h00
`define PWT_REFRESH_SECOND 8'hFF

// field positions
`define PWT_PRESCALE_SEL_POS 7
`define PWT_PROTECT_EN_POS 7
`define PWT_UNDERFLOW_ACT_POS 2
`define PWT_AUTO_START_POS 0
`define PWT_PROTECT_INIT_POS 7
`define PWT_RUNNING_POS 16

// reset and erased values
`define PWT_OPTION_ERASED 8'hFF
`define PWT_PROTECT_ON_READ 8'h80

// counter widths and reload values
`define PWT_COUNT_W 15
`define PWT_RELOAD_NORMAL 15'h7FFF
`define PWT_RELOAD_PROTECT 15'h0FFF

// prescaler ratios
`define PWT_DIV_W 9
`define PWT_PRESCALE_LOW 9'd16
`define PWT_PRESCALE_HIGH 9'd128

// timing: cpu clock and low-speed oscillator rates in hz
`define PWT_CLK_HZ 40000000
`define PWT_LOCO_HZ 125000

`endif

// >>> rtl/pwt_watchdog.v
// program watchdog timer with apb register access
// assumes option byte pins are stable from reset release onward
//
// Register access over APB and the address map were decided locally.
`include "pwt_regs.vh"

module pwt_watchdog #(
  parameter CLK_HZ = `PWT_CLK_HZ,
  parameter LOCO_HZ = `PWT_LOCO_HZ,
  parameter [`PWT_DIV_W-1:0] PRESC_LOW = `PWT_PRESCALE_LOW,
  parameter [`PWT_DIV_W-1:0] PRESC_HIGH = `PWT_PRESCALE_HIGH
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // option byte from flash
  input wire [7:0] option_byte,
  input wire flash_erased,
  // low power mode status
  input wire stop_mode,
  input wire wait_mode,
  // underflow outputs
  output reg wdt_irq,
  output reg wdt_reset_req
);

  localparam integer LOCO_RATIO = CLK_HZ / LOCO_HZ;
  localparam [`PWT_DIV_W-1:0] LOCO_DIV = LOCO_RATIO[`PWT_DIV_W-1:0];

  // option capture state
  reg opt_done_q;
  // control state
  reg started_q;
  reg prescale_select_bit_q;
  reg protect_enable_bit_q;
  reg protect_arm_q;
  reg underflow_action_bit_q;
  reg refresh_arm_q;
  reg [`PWT_COUNT_W-1:0] count_q;

  wire [7:0] opt_eff;
  wire acc;
  wire wr;
  wire [7:0] wbyte;
  wire hit_refresh;
  wire hit_start;
  wire hit_control;
  wire hit_protect;
  wire hit_pmode;
  wire hit_count;
  wire mapped;
  wire refresh_ok;
  wire protect_set;
  wire low_power;
  wire run;
  wire presc_tick;
  wire loco_tick;
  wire src_tick;
  wire underflow;
  wire reset_action;
  wire [`PWT_DIV_W-1:0] presc_ratio;
  wire [`PWT_COUNT_W-1:0] reload_val;
  reg [31:0] rdata_d;

  // erased flash block reads as all ones
  assign opt_eff = flash_erased ? `PWT_OPTION_ERASED : option_byte;

  // bus decode, zero wait states
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign wbyte = pwdata[7:0];
  assign hit_refresh = (paddr == `PWT_REFRESH_OFF);
  assign hit_start = (paddr == `PWT_START_OFF);
  assign hit_control = (paddr == `PWT_CONTROL_OFF);
  assign hit_protect = (paddr == `PWT_PROTECT_OFF);
  assign hit_pmode = (paddr == `PWT_PMODE_OFF);
  assign hit_count = (paddr == `PWT_COUNT_OFF);
  assign mapped = hit_refresh | hit_start | hit_control | hit_protect |
                  hit_pmode | hit_count;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // second half of the refresh pair
  assign refresh_ok = wr & hit_refresh & refresh_arm_q &
                      (wbyte == `PWT_REFRESH_SECOND);

  // protection sets only after an armed write of one
  assign protect_set = wr & hit_protect & protect_arm_q &
                       pwdata[`PWT_PROTECT_EN_POS];

  // tick selection and gating
  assign low_power = stop_mode | wait_mode;
  assign run = started_q & (protect_enable_bit_q | ~low_power);
  assign presc_ratio = prescale_select_bit_q ? PRESC_HIGH :
                       PRESC_LOW;
  assign src_tick = protect_enable_bit_q ? loco_tick : presc_tick;
  assign underflow = run & src_tick & (count_q == {`PWT_COUNT_W{1'b0}});
  assign reload_val = protect_enable_bit_q ? `PWT_RELOAD_PROTECT :
                      `PWT_RELOAD_NORMAL;
  assign reset_action = protect_enable_bit_q | underflow_action_bit_q;

  // cpu clock prescaler, halted when stopped or in low power
  pwt_divider #(
    .W(`PWT_DIV_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .enable(started_q & ~protect_enable_bit_q & ~low_power),
    .ratio(presc_ratio),
    .tick(presc_tick)
  );

  // low-speed oscillator rate, free running
  pwt_divider #(
    .W(`PWT_DIV_W)
  ) u_loco (
    .pclk(pclk),
    .presetn(presetn),
    .enable(1'b1),
    .ratio(LOCO_DIV),
    .tick(loco_tick)
  );

  // option byte capture on the first edge after reset release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opt_done_q <= 1'b0;
    end
    else if (!opt_done_q)
    begin
      opt_done_q <= 1'b1;
    end
  end

  // start control
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      started_q <= 1'b0;
    end
    else if (!opt_done_q)
    begin
      started_q <= ~opt_eff[`PWT_AUTO_START_POS];
    end
    else if (wr & hit_start)
    begin
      started_q <= 1'b1;
    end
  end

  // protection enable, sticky once set
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      protect_enable_bit_q <= 1'b0;
      protect_arm_q <= 1'b0;
    end
    else if (!opt_done_q)
    begin
      protect_enable_bit_q <= ~opt_eff[`PWT_PROTECT_INIT_POS];
      protect_arm_q <= 1'b0;
    end
    else if (!protect_enable_bit_q && wr && hit_protect)
    begin
      protect_arm_q <= ~pwdata[`PWT_PROTECT_EN_POS];
      if (protect_set)
      begin
        protect_enable_bit_q <= 1'b1;
      end
    end
  end

  // prescaler select and underflow action bits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prescale_select_bit_q <= 1'b0;
      underflow_action_bit_q <= 1'b0;
    end
    else
    begin
      if (wr & hit_control)
      begin
        prescale_select_bit_q <= pwdata[`PWT_PRESCALE_SEL_POS];
      end
      if (wr & hit_pmode)
      begin
        underflow_action_bit_q <= pwdata[`PWT_UNDERFLOW_ACT_POS];
      end
    end
  end

  // refresh sequence tracker
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      refresh_arm_q <= 1'b0;
    end
    else if (wr & hit_refresh)
    begin
      // any other value breaks the pair
      refresh_arm_q <= (wbyte == `PWT_REFRESH_FIRST);
    end
  end

  // down counter
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= `PWT_RELOAD_NORMAL;
    end
    else if (!opt_done_q)
    begin
      count_q <= opt_eff[`PWT_PROTECT_INIT_POS] ? `PWT_RELOAD_NORMAL :
                 `PWT_RELOAD_PROTECT;
    end
    else if (protect_set & ~protect_enable_bit_q)
    begin
      // shorter period takes effect at once
      count_q <= `PWT_RELOAD_PROTECT;
    end
    else if (refresh_ok | underflow)
    begin
      count_q <= reload_val;
    end
    else if (run & src_tick)
    begin
      count_q <= count_q - {{(`PWT_COUNT_W-1){1'b0}}, 1'b1};
    end
  end

  // underflow outputs, one-cycle pulses
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_irq <= 1'b0;
      wdt_reset_req <= 1'b0;
    end
    else
    begin
      wdt_irq <= underflow & ~reset_action;
      wdt_reset_req <= underflow & reset_action;
    end
  end

  // read mux
  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (hit_control)
    begin
      rdata_d[`PWT_PRESCALE_SEL_POS] = prescale_select_bit_q;
      rdata_d[4:0] = count_q[14:10];
    end
    else if (hit_protect)
    begin
      rdata_d[7:0] = protect_enable_bit_q ? `PWT_PROTECT_ON_READ :
                     8'h00;
    end
    else if (hit_pmode)
    begin
      rdata_d[`PWT_UNDERFLOW_ACT_POS] = underflow_action_bit_q;
    end
    else if (hit_count)
    begin
      rdata_d[`PWT_COUNT_W-1:0] = count_q;
      rdata_d[`PWT_RUNNING_POS] = run;
    end
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel & ~penable & ~pwrite)
    begin
      prdata <= rdata_d;
    end
  end

endmodule

// >>> verif/pwt_tb.sv
// self-checking bench for the watchdog over apb
// assumes design and checker are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic flash_erased, stop_mode, wait_mode, wdt_irq, wdt_reset_req;
  logic [7:0] paddr, option_byte;
  logic [31:0] pwdata, prdata, r, c;
  int err_total, checks_done, n, t;
  // write flag, address, write data or expected read
  logic [24:0] rows [11] = '{
    {1'b0, 8'h0C, 16'h0000},
    {1'b0, 8'h14, 16'h7FFF},
    {1'b0, 8'h08, 16'h001F},
    {1'b1, 8'h08, 16'h0080},
    {1'b0, 8'h08, 16'h009F},
    {1'b1, 8'h08, 16'h0000},
    {1'b1, 8'h10, 16'h0004},
    {1'b0, 8'h10, 16'h0004},
    {1'b1, 8'h10, 16'h0000},
    {1'b0, 8'h00, 16'h0000},
    {1'b0, 8'h20, 16'h0000}};

  // faster oscillator and prescaler keep underflow runs short
  pwt_watchdog #(.LOCO_HZ(10_000_000), .PRESC_LOW(9'd1),
    .PRESC_HIGH(9'd8)) u_pwt_watchdog (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .option_byte, .flash_erased, .stop_mode, .wait_mode,
    .wdt_irq, .wdt_reset_req);

  always #12.5 pclk = ~pclk;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, x, input string m);
    checks_done++;
    if (g !== x)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 9);
    if (pready !== 1'b1)
    begin
      err_total++;
      print_verdict();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rst(input logic [7:0] ob, input logic fe);
    presetn <= 1'b0;
    option_byte <= ob;
    flash_erased <= fe;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // bounded wait for an underflow pulse, cycles counted in t
  task automatic wait_out(input logic irq, input int lim);
    t = 0;
    while ((irq ? wdt_irq : wdt_reset_req) !== 1'b1 && t < lim)
    begin
      @(posedge pclk);
      t++;
    end
    if (t >= lim)
    begin
      err_total++;
      print_verdict();
    end
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {stop_mode, wait_mode} = 2'b00;
    @(posedge pclk);
    rst(8'h81, 1'b0);
    foreach (rows[i])
    begin
      apb(rows[i][24], rows[i][23:16], {16'h0, rows[i][15:0]});
      if (!rows[i][24])
        chk(r, rows[i][15:0], "read");
    end
    $display("registers done");
    apb(1, 8'h04, 0);
    repeat (64) @(posedge pclk);
    apb(0, 8'h14, 0);
    chk(r[16] && r[14:0] < 15'h7FFF, 1, "start");
    // 83 cycles between samples: ratio 1 then ratio 8
    for (int k = 0; k < 2; k++)
    begin
      apb(1, 8'h08, k << 7);
      apb(0, 8'h14, 0);
      c = r;
      repeat (80) @(posedge pclk);
      apb(0, 8'h14, 0);
      c = c - r;
      chk(k ? (c[14:0] inside {[9:12]}) : (c[14:0] inside {[80:86]}),
          1, "ratio");
    end
    apb(1, 8'h08, 0);
    for (int k = 0; k < 2; k++)
    begin
      stop_mode <= (k == 0);
      wait_mode <= (k == 1);
      apb(0, 8'h14, 0);
      c = r;
      repeat (100) @(posedge pclk);
      apb(0, 8'h14, 0);
      chk(r, c, "frozen");
    end
    stop_mode <= 1'b0;
    wait_mode <= 1'b0;
    repeat (400) @(posedge pclk);
    apb(0, 8'h14, 0);
    c = r;
    apb(1, 8'h00, 0);
    apb(1, 8'h00, 8'h12);
    apb(1, 8'h00, 8'hFF);
    apb(0, 8'h14, 0);
    chk(r[14:0] <= c[14:0], 1, "broken refresh");
    apb(1, 8'h00, 0);
    apb(1, 8'h00, 8'hFF);
    apb(0, 8'h14, 0);
    chk(r[14:0] >= 15'h7FFE, 1, "refresh");
    $display("start and refresh done");
    apb(1, 8'h0C, 0);
    apb(1, 8'h0C, 8'h80);
    apb(0, 8'h0C, 0);
    chk(r, 32'h0000_0080, "protect on");
    apb(1, 8'h0C, 0);
    apb(0, 8'h0C, 0);
    chk(r, 32'h0000_0080, "sticky");
    stop_mode <= 1'b1;
    apb(1, 8'h00, 0);
    apb(1, 8'h00, 8'hFF);
    wait_out(1'b0, 20000);
    chk(t > 16370 && t < 16400, 1, "period");
    $display("protection done");
    stop_mode <= 1'b0;
    rst(8'h00, 1'b1);
    apb(0, 8'h0C, 0);
    chk(r, 0, "erased protect");
    apb(0, 8'h14, 0);
    chk(r[16], 0, "erased start");
    rst(8'h00, 1'b0);
    apb(0, 8'h0C, 0);
    chk(r, 32'h0000_0080, "protect init");
    apb(0, 8'h14, 0);
    chk(r[16], 1, "auto start");
    $display("reset options done");
    rst(8'h80, 1'b0);
    wait_out(1'b1, 33000);
    chk(t > 32760 && t < 32780 && !wdt_reset_req, 1, "irq");
    apb(1, 8'h10, 32'h0000_0004);
    wait_out(1'b0, 33000);
    chk(t > 32750 && t < 32780 && !wdt_irq, 1, "reset");
    $display("underflow actions done");
    print_verdict();
  end
endmodule

// >>> verif/pwt_watchdog_sva.sv
// checker for the watchdog apb reads and underflow pulses
// assumes it is bound to pwt_watchdog and sees its ports only
module pwt_watchdog_sva (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  // underflow
  input wire wdt_irq,
  input wire wdt_reset_req
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic prot_q;
  sequence rd(a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  // protection seen on by a read
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      prot_q <= 1'b0;
    else if (psel && penable && !pwrite && paddr == 8'h0C
             && prdata == 32'h80)
      prot_q <= 1'b1;
  chk_pulse_one: assert property (
    wdt_irq || wdt_reset_req |=> !wdt_irq && !wdt_reset_req)
    else $error("underflow pulse too long");
  chk_action_excl: assert property (
    !(wdt_irq && wdt_reset_req))
    else $error("both underflow actions");
  chk_prot_sticky: assert property (
    prot_q ##0 rd(8'h0C) |=> prdata == 32'h80)
    else $error("protection cleared");
  chk_prot_value: assert property (
    rd(8'h0C) |=> prdata == 32'h0 || prdata == 32'h80)
    else $error("bad protect value");
  chk_count_width: assert property (
    rd(8'h14) |=> prdata[31:17] == 15'h0 && !prdata[15])
    else $error("count wider than 15 bits");
  chk_ctrl_field: assert property (
    rd(8'h08) |=> (prdata & 32'hFFFF_FF60) == 32'h0)
    else $error("bad control bits");
  chk_action_field: assert property (
    rd(8'h10) |=> (prdata & 32'hFFFF_FFFB) == 32'h0)
    else $error("bad action bits");
  chk_refresh_wo: assert property (
    rd(8'h00) |=> prdata == 32'h0)
    else $error("refresh reads nonzero");
endmodule

bind pwt_watchdog pwt_watchdog_sva u_pwt_watchdog_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .wdt_irq(wdt_irq),
  .wdt_reset_req(wdt_reset_req)
);
